//--- pkg/afb_pkg.sv
// constants shared by both ends of the almost-full flag bus link
// ----------------------------------------------------------------
// Summary of operation
// - direct mode: strobe latches addressed group
// - polled mode: strobe held low
// - no strobe before programming done goes low
// - polled: groups rotate, group one again fifth
// - sync high while first group shown
// - token out pulses with last group
// - token in: load first group next edge
// - single device: token loop or tie low
// - chain: last token loops to first
// - address: 3 device bits, 5 queue bits
// - act only when device bits match ID
// - ID captured at master reset, kept steady
// - single device: ID and top bits zero
// - any distinct ID, any chain order
// - width pins pick x9, x18, x36
// - master select sampled at master reset
// - master drives first, slaves high impedance
// - master reset is high, low, high
// - master: output enable low drives data
// - slave: data off until read selected
// - flag mode pin: high polled, low direct
// ----------------------------------------------------------------
package afb_pkg;
  localparam int ADDR_W  = 8;
  localparam int DEV_W   = 3;
  localparam int QUEUE_W = 5;
  localparam int DEV_LSB = 5;
  localparam int GRP_LSB = 3;
  localparam int GROUP_W = 8;
  localparam int QUEUES  = 32;
  localparam int GRP_SEL_W = 2;
  localparam logic [1:0] GRP_FIRST = 2'h0;
  localparam logic [1:0] GRP_LAST  = 2'h3;
  // port width codes
  localparam logic [1:0] WID_36 = 2'h0;
  localparam logic [1:0] WID_18 = 2'h1;
  localparam logic [1:0] WID_9  = 2'h2;
  // strap vector layout
  localparam int STRAP_W      = 9;
  localparam int STRAP_ID_LSB = 0;
  localparam int STRAP_MASTER_SELECT   = 3;
  localparam int STRAP_POLL   = 4;
  localparam int STRAP_IW     = 5;
  localparam int STRAP_OW     = 6;
  localparam int STRAP_BM     = 7;
  localparam int STRAP_SPARE  = 8;
  // master reset timing at the 100 ns clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int MRS_LOW_NS    = 200;
  localparam int MRS_REC_NS    = 100;
  localparam logic [3:0] MRS_LOW_CYC =
    4'((MRS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] MRS_REC_CYC =
    4'((MRS_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_OWN = 1'b1} afb_own_t;
  typedef enum logic [1:0] {MRS_RUN = 2'b00, MRS_LOW = 2'b01, MRS_REC = 2'b10} afb_mrs_t;
endpackage : afb_pkg

//--- pkg/afb_link_if.sv
// pin-level link between the flag-bus device and its host logic
`timescale 1ns/100ps
interface afb_link_if;
  logic                     master_reset_n;
  logic [afb_pkg::DEV_W-1:0] id_pins;
  logic                     master_select;
  logic                     flag_poll_select;
  logic                     input_width_sel;
  logic                     output_width_sel;
  logic                     bus_matching_sel;
  logic                     serial_program_done;
  logic                     full_bus_strobe;
  logic [afb_pkg::ADDR_W-1:0] write_queue_address;
  logic                     write_select;
  logic [afb_pkg::ADDR_W-1:0] read_queue_address;
  logic                     read_select;
  logic                     output_enable_n;
  logic [afb_pkg::GROUP_W-1:0] almost_full_bus;
  logic                     almost_full_bus_oe_n;
  logic                     full_bus_sync;
  logic                     full_token_in;
  logic                     full_token_out;

  modport dev (
    input  master_reset_n, id_pins, master_select, flag_poll_select,
    input  input_width_sel, output_width_sel, bus_matching_sel,
    input  full_bus_strobe, write_queue_address, write_select,
    input  read_queue_address, read_select, output_enable_n, full_token_in,
    output serial_program_done, almost_full_bus, almost_full_bus_oe_n,
    output full_bus_sync, full_token_out
  );
  modport host (
    output master_reset_n, id_pins, master_select, flag_poll_select,
    output input_width_sel, output_width_sel, bus_matching_sel,
    output full_bus_strobe, write_queue_address, write_select,
    output read_queue_address, read_select, output_enable_n,
    input  serial_program_done, almost_full_bus, almost_full_bus_oe_n,
    input  full_bus_sync, full_token_out
  );
endinterface : afb_link_if

//--- design/afb_strap_latch.sv
// strap latch: follows the strap pins while master reset is low, holds after
`timescale 1ns/100ps
module afb_strap_latch #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         capture,
  input  wire logic [W-1:0] strap_in,
  output logic      [W-1:0] strap_q
);
  // async reset loads a constant; the pins are taken only by the clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_q <= '0;
    end else if (capture) begin
      strap_q <= strap_in; // last value before release is kept
    end
  end
endmodule : afb_strap_latch

//--- design/afb_flag_dev.sv
// device end: almost-full flag bus, token chain, ID match and output control
`timescale 1ns/100ps
module afb_flag_dev (
  input  wire logic                         SYS_CLK,
  input  wire logic                         NRST,
  afb_link_if.dev                           LNK,
  input  wire logic [afb_pkg::QUEUES-1:0]   QUEUE_ALMOST_FULL,
  input  wire logic                         PROG_DONE_N,
  output logic                              WRITE_HIT,
  output logic [afb_pkg::QUEUE_W-1:0]       WRITE_QUEUE,
  output logic                              READ_HIT,
  output logic [afb_pkg::QUEUE_W-1:0]       READ_QUEUE,
  output logic [afb_pkg::DEV_W-1:0]         DEV_ID,
  output logic                              IS_MASTER,
  output logic                              POLL_MODE,
  output logic [1:0]                        IN_WIDTH,
  output logic [1:0]                        OUT_WIDTH,
  output logic                              WIDTH_BAD,
  output logic                              IN_RESET,
  output logic                              QOUT_OE_N
);
  // ----------------------------------------------------------------
  // id match, used on both address buses
  // ----------------------------------------------------------------
  function automatic logic id_match(input logic [afb_pkg::ADDR_W-1:0] addr,
                                    input logic [afb_pkg::DEV_W-1:0]  id);
    id_match = (addr[afb_pkg::ADDR_W-1:afb_pkg::DEV_LSB] == id);
  endfunction : id_match

  // ----------------------------------------------------------------
  // master reset and straps
  // ----------------------------------------------------------------
  logic                          in_mrs;
  logic                          mrs_q_r;
  logic                          mrs_end;
  logic [afb_pkg::STRAP_W-1:0]   strap_pins;
  logic [afb_pkg::STRAP_W-1:0]   strap_r;
  logic [afb_pkg::DEV_W-1:0]     id_r;
  logic                          master_r;
  logic                          poll_r;

  // reset is the low phase of a high-low-high on the pin
  assign in_mrs  = ~LNK.master_reset_n;
  assign mrs_end = mrs_q_r & ~in_mrs;

  assign strap_pins = {1'b0, LNK.bus_matching_sel, LNK.output_width_sel,
                       LNK.input_width_sel, LNK.flag_poll_select,
                       LNK.master_select, LNK.id_pins};

  afb_strap_latch #(.W(afb_pkg::STRAP_W)) u_straps (
    .clk      (SYS_CLK),
    .rst_n    (NRST),
    .capture  (in_mrs),
    .strap_in (strap_pins),
    .strap_q  (strap_r)
  );

  // straps sampled at master reset
  assign id_r     = strap_r[afb_pkg::STRAP_ID_LSB +: afb_pkg::DEV_W];
  assign master_r = strap_r[afb_pkg::STRAP_MASTER_SELECT];
  assign poll_r   = strap_r[afb_pkg::STRAP_POLL];

  // remember reset level to find the release edge
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      mrs_q_r <= 1'b1;
    end else begin
      mrs_q_r <= in_mrs;
    end
  end

  // ----------------------------------------------------------------
  // width selection
  // ----------------------------------------------------------------
  logic iw;
  logic ow;
  logic bm;
  assign iw = strap_r[afb_pkg::STRAP_IW];
  assign ow = strap_r[afb_pkg::STRAP_OW];
  assign bm = strap_r[afb_pkg::STRAP_BM];

  // bm low keeps both ports at x36; high narrows the side iw picks
  assign IN_WIDTH  = (bm && !iw) ? (ow ? afb_pkg::WID_9 : afb_pkg::WID_18)
                                 : afb_pkg::WID_36;
  assign OUT_WIDTH = (bm && iw)  ? (ow ? afb_pkg::WID_9 : afb_pkg::WID_18)
                                 : afb_pkg::WID_36;
  // every code keeps one port at x36, so no strap can be illegal here
  assign WIDTH_BAD = (IN_WIDTH != afb_pkg::WID_36) && (OUT_WIDTH != afb_pkg::WID_36);

  // ----------------------------------------------------------------
  // queue selection on the write and read address buses
  // ----------------------------------------------------------------
  logic wr_hit;
  logic rd_hit;
  logic wr_hit_r;
  logic rd_hit_r;
  logic rd_seen_r;
  logic [afb_pkg::QUEUE_W-1:0] wq_r;
  logic [afb_pkg::QUEUE_W-1:0] rq_r;

  assign wr_hit = ~in_mrs & LNK.write_select & id_match(LNK.write_queue_address, id_r);
  assign rd_hit = ~in_mrs & LNK.read_select  & id_match(LNK.read_queue_address,  id_r);

  // only a matching device reports a selection to its queue logic
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      wr_hit_r <= 1'b0;
      rd_hit_r <= 1'b0;
      wq_r     <= '0;
      rq_r     <= '0;
    end else begin
      wr_hit_r <= wr_hit;
      rd_hit_r <= rd_hit;
      if (wr_hit) wq_r <= LNK.write_queue_address[afb_pkg::QUEUE_W-1:0];
      if (rd_hit) rq_r <= LNK.read_queue_address[afb_pkg::QUEUE_W-1:0];
    end
  end

  // a slave earns its output drive by its first read selection
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rd_seen_r <= 1'b0;
    end else if (in_mrs) begin
      rd_seen_r <= 1'b0; // slaves go quiet again after master reset
    end else if (rd_hit) begin
      rd_seen_r <= 1'b1;
    end
  end

  // output enable is asynchronous, so it goes straight to the pad control
  assign QOUT_OE_N = LNK.output_enable_n | ~(master_r | rd_seen_r);

  // ----------------------------------------------------------------
  // flag bus ownership and group rotation
  // ----------------------------------------------------------------
  afb_pkg::afb_own_t             own_r;
  afb_pkg::afb_own_t             own_nxt;
  logic [1:0]                    grp_r;
  logic [1:0]                    grp_nxt;
  logic                          sync_r;
  logic                          tok_r;
  logic [afb_pkg::GROUP_W-1:0]   flags_r;
  logic                          master_start;
  logic                          poll_first;
  logic                          poll_next;
  logic                          poll_drop;
  logic                          dir_take;
  logic                          dir_drop;

  // master opens the bus at release, in either mode
  assign master_start = mrs_end & master_r;
  // token in, or the master's own start, loads group one next edge
  assign poll_first = poll_r & ~in_mrs & (master_start | LNK.full_token_in);
  assign poll_next  = poll_r & ~in_mrs & (own_r == afb_pkg::BUS_OWN) &
                      (grp_r != afb_pkg::GRP_LAST);
  assign poll_drop  = poll_r & ~in_mrs & (own_r == afb_pkg::BUS_OWN) &
                      (grp_r == afb_pkg::GRP_LAST);
  // direct mode: strobe with matching ID takes the bus, else lets it go
  assign dir_take = ~poll_r & ~in_mrs & LNK.full_bus_strobe &
                    id_match(LNK.write_queue_address, id_r);
  assign dir_drop = ~poll_r & ~in_mrs & LNK.full_bus_strobe & ~dir_take;

  assign own_nxt = in_mrs                           ? afb_pkg::BUS_IDLE :
                   (poll_first | dir_take | (~poll_r & master_start)) ? afb_pkg::BUS_OWN :
                   (poll_drop | dir_drop)           ? afb_pkg::BUS_IDLE : own_r;
  assign grp_nxt = in_mrs     ? afb_pkg::GRP_FIRST :
                   poll_first ? afb_pkg::GRP_FIRST :
                   dir_take   ? LNK.write_queue_address[afb_pkg::DEV_LSB-1:afb_pkg::GRP_LSB] :
                   poll_next  ? 2'(grp_r + 2'h1) : grp_r;

  // bus, sync and token move together on the same write clock edge
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      own_r   <= afb_pkg::BUS_IDLE;
      grp_r   <= afb_pkg::GRP_FIRST;
      sync_r  <= 1'b0;
      tok_r   <= 1'b0;
      flags_r <= '0;
    end else begin
      own_r   <= own_nxt;
      grp_r   <= grp_nxt;
      sync_r  <= poll_r & (own_nxt == afb_pkg::BUS_OWN) &
                 (grp_nxt == afb_pkg::GRP_FIRST);
      tok_r   <= poll_r & (own_nxt == afb_pkg::BUS_OWN) &
                 (grp_nxt == afb_pkg::GRP_LAST);
      flags_r <= QUEUE_ALMOST_FULL[grp_nxt * afb_pkg::GROUP_W +: afb_pkg::GROUP_W];
    end
  end

  // only the owner drives the shared bus; others float it
  assign LNK.almost_full_bus      = flags_r;
  assign LNK.almost_full_bus_oe_n = (own_r != afb_pkg::BUS_OWN);
  assign LNK.full_bus_sync        = sync_r;
  assign LNK.full_token_out       = tok_r;
  assign LNK.serial_program_done  = PROG_DONE_N;

  // ----------------------------------------------------------------
  // user-side status
  // ----------------------------------------------------------------
  assign WRITE_HIT   = wr_hit_r;
  assign WRITE_QUEUE = wq_r;
  assign READ_HIT    = rd_hit_r;
  assign READ_QUEUE  = rq_r;
  assign DEV_ID      = id_r;      // any value, chain order free
  assign IS_MASTER   = master_r;
  assign POLL_MODE   = poll_r;
  assign IN_RESET    = mrs_q_r;
endmodule : afb_flag_dev

//--- design/afb_flag_host.sv
// host end: master reset sequence, straps, selections and flag bus capture
`timescale 1ns/100ps
module afb_flag_host (
  input  wire logic                         SYS_CLK,
  input  wire logic                         NRST,
  afb_link_if.host                          LNK,
  input  wire logic                         RESET_REQ,
  output logic                              RESET_BUSY,
  input  wire logic [afb_pkg::STRAP_W-1:0]  STRAPS,
  input  wire logic                         FSEL_REQ,
  input  wire logic [afb_pkg::DEV_W-1:0]    FSEL_DEV,
  input  wire logic [1:0]                   FSEL_GROUP,
  output logic                              FSEL_READY,
  input  wire logic                         WSEL_REQ,
  input  wire logic [afb_pkg::ADDR_W-1:0]   WSEL_ADDR,
  output logic                              WSEL_READY,
  input  wire logic                         RSEL_REQ,
  input  wire logic [afb_pkg::ADDR_W-1:0]   RSEL_ADDR,
  input  wire logic                         OUT_ENABLE_N,
  output logic [afb_pkg::GROUP_W-1:0]       FLAG_DATA,
  output logic                              FLAG_VALID,
  output logic [1:0]                        FLAG_GROUP
);
  // ----------------------------------------------------------------
  // master reset sequencer
  // ----------------------------------------------------------------
  afb_pkg::afb_mrs_t             st_r;
  logic [3:0]                    cnt_r;
  logic [afb_pkg::STRAP_W-1:0]   strap_r;
  logic                          run;

  // high, low for the set time, then high again
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st_r    <= afb_pkg::MRS_RUN;
      cnt_r   <= '0;
      strap_r <= '0;
    end else begin
      unique case (st_r)
        afb_pkg::MRS_RUN: begin
          if (RESET_REQ) begin
            st_r    <= afb_pkg::MRS_LOW;
            cnt_r   <= afb_pkg::MRS_LOW_CYC;
            strap_r <= STRAPS; // held unchanged until the next reset
          end
        end
        afb_pkg::MRS_LOW: begin
          cnt_r <= 4'(cnt_r - 4'h1);
          if (cnt_r == 4'h1) begin
            st_r  <= afb_pkg::MRS_REC;
            cnt_r <= afb_pkg::MRS_REC_CYC;
          end
        end
        afb_pkg::MRS_REC: begin
          cnt_r <= 4'(cnt_r - 4'h1);
          if (cnt_r == 4'h1) st_r <= afb_pkg::MRS_RUN;
        end
        default: st_r <= afb_pkg::MRS_RUN;
      endcase
    end
  end

  assign run        = (st_r == afb_pkg::MRS_RUN);
  assign RESET_BUSY = ~run;

  assign LNK.master_reset_n   = (st_r != afb_pkg::MRS_LOW);
  assign LNK.id_pins          = strap_r[afb_pkg::STRAP_ID_LSB +: afb_pkg::DEV_W];
  assign LNK.master_select    = strap_r[afb_pkg::STRAP_MASTER_SELECT];
  assign LNK.flag_poll_select = strap_r[afb_pkg::STRAP_POLL];
  assign LNK.input_width_sel  = strap_r[afb_pkg::STRAP_IW];
  assign LNK.output_width_sel = strap_r[afb_pkg::STRAP_OW];
  assign LNK.bus_matching_sel = strap_r[afb_pkg::STRAP_BM];

  // ----------------------------------------------------------------
  // selections; the flag strobe shares the write address bus
  // ----------------------------------------------------------------
  logic                        fsel_ok;
  logic                        full_bus_strobe_r;
  logic                        wsel_r;
  logic                        rsel_r;
  logic [afb_pkg::ADDR_W-1:0]  waddr_r;
  logic [afb_pkg::ADDR_W-1:0]  raddr_r;

  // strobe never in polled mode nor before programming is done
  assign fsel_ok    = run & ~strap_r[afb_pkg::STRAP_POLL] & ~LNK.serial_program_done;
  assign FSEL_READY = fsel_ok;
  // the strobe wins the shared address bus, so a write waits a cycle
  assign WSEL_READY = run & ~(FSEL_REQ & fsel_ok);

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      full_bus_strobe_r  <= 1'b0;
      wsel_r  <= 1'b0;
      rsel_r  <= 1'b0;
      waddr_r <= '0;
      raddr_r <= '0;
    end else begin
      full_bus_strobe_r <= FSEL_REQ & fsel_ok;
      wsel_r <= WSEL_REQ & WSEL_READY;
      rsel_r <= RSEL_REQ & run;
      if (FSEL_REQ & fsel_ok) begin
        waddr_r <= {FSEL_DEV, FSEL_GROUP, 3'h0};
      end else if (WSEL_REQ & WSEL_READY) begin
        waddr_r <= WSEL_ADDR;
      end
      if (RSEL_REQ & run) raddr_r <= RSEL_ADDR;
    end
  end

  assign LNK.full_bus_strobe     = full_bus_strobe_r;
  assign LNK.write_select        = wsel_r;
  assign LNK.write_queue_address = waddr_r;
  assign LNK.read_select         = rsel_r;
  assign LNK.read_queue_address  = raddr_r;
  // output enable is asynchronous at the device; passed as is
  assign LNK.output_enable_n     = OUT_ENABLE_N;

  // ----------------------------------------------------------------
  // flag bus capture; sync restarts the group count
  // ----------------------------------------------------------------
  logic [afb_pkg::GROUP_W-1:0] fdat_r;
  logic                        fval_r;
  logic [1:0]                  fgrp_r;

  // token wiring between devices is board level and outside this end
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      fdat_r <= '0;
      fval_r <= 1'b0;
      fgrp_r <= '0;
    end else begin
      fdat_r <= LNK.almost_full_bus;
      fval_r <= ~LNK.almost_full_bus_oe_n;
      fgrp_r <= LNK.full_bus_sync ? afb_pkg::GRP_FIRST : 2'(fgrp_r + 2'h1);
    end
  end

  assign FLAG_DATA  = fdat_r;
  assign FLAG_VALID = fval_r;
  assign FLAG_GROUP = fgrp_r;
endmodule : afb_flag_host

//--- verification/afb_link_properties.sv
// concurrent checks on the flag-bus link between host end and device end
`timescale 1ns/100ps
module afb_link_properties (
  input wire logic       SYS_CLK,
  input wire logic       NRST,
  input wire logic       master_reset_n,
  input wire logic       master_select,
  input wire logic [2:0] id_pins,
  input wire logic       serial_program_done,
  input wire logic       full_bus_strobe,
  input wire logic [7:0] write_queue_address,
  input wire logic       almost_full_bus_oe_n,
  input wire logic       full_bus_sync,
  input wire logic       full_token_in,
  input wire logic       full_token_out
);
  // ----------------------------------------
  // link checks
  // ----------------------------------------
  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // rotation checks stop at a master reset, which may cut a rotation short
  mrs_pulse_a: assert property (
    $fell(master_reset_n) |=> !master_reset_n ##1 master_reset_n) else $error("bad reset pulse");
  master_go_a: assert property (
    $rose(master_reset_n) && master_select |=> !almost_full_bus_oe_n) else $error("master idle");
  slave_off_a: assert property (
    $rose(master_reset_n) && !master_select |=> almost_full_bus_oe_n[*2])
    else $error("slave drives bus");
  grp_cycle_a: assert property (disable iff (!NRST || !master_reset_n)
    full_bus_sync |=> !full_bus_sync[*3] ##1 full_bus_sync) else $error("bad rotation");
  token_pos_a: assert property (disable iff (!NRST || !master_reset_n)
    full_bus_sync |-> ##3 full_token_out ##1 !full_token_out) else $error("token misplaced");
  token_load_a: assert property (disable iff (!NRST || !master_reset_n)
    full_token_out && full_token_in |=> full_bus_sync && !almost_full_bus_oe_n)
    else $error("token not taken");
  strobe_prog_a: assert property (
    full_bus_strobe |-> !serial_program_done) else $error("strobe too early");
  strobe_miss_a: assert property (
    full_bus_strobe && write_queue_address[7:5] != id_pins |=> almost_full_bus_oe_n)
    else $error("foreign strobe kept bus");
  token_c: cover property (full_token_out && full_token_in);
  strobe_c: cover property (full_bus_strobe ##1 !almost_full_bus_oe_n);
  release_c: cover property ($rose(master_reset_n));
endmodule : afb_link_properties

//--- verification/tb_top.sv
// self-checking bench: host end and one device end joined by the link
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        reset_req = 1'b0;
  logic        fsel_req = 1'b0;
  logic        wsel_req = 1'b0;
  logic        rsel_req = 1'b0;
  logic        oe_n = 1'b1;
  logic        prog_n = 1'b0;
  logic [8:0]  straps = 9'h000;
  logic [2:0]  fsel_dev = 3'h0;
  logic [1:0]  fsel_grp = 2'h0;
  logic [7:0]  sel_addr = 8'h00;
  logic [31:0] qaf = 32'h96c3_1e78;
  logic        reset_busy, fsel_ready, w_hit, r_hit, is_master, poll, qout_oe_n;
  logic        in_reset, width_bad, wsel_ready, f_val;
  logic [4:0]  w_q, r_q;
  logic [7:0]  f_dat;
  logic [2:0]  dev_id;
  logic [1:0]  in_w, out_w, f_grp;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  afb_link_if lnk ();
  // single device: token looped in polled mode, tied low in direct mode
  assign lnk.full_token_in = straps[afb_pkg::STRAP_POLL] & lnk.full_token_out;
  always #50 sys_clk = ~sys_clk;
  afb_flag_host afb_flag_host_inst (.SYS_CLK(sys_clk), .NRST(nrst), .LNK(lnk.host),
    .RESET_REQ(reset_req), .RESET_BUSY(reset_busy), .STRAPS(straps), .FSEL_REQ(fsel_req),
    .FSEL_DEV(fsel_dev), .FSEL_GROUP(fsel_grp), .FSEL_READY(fsel_ready), .WSEL_REQ(wsel_req),
    .WSEL_ADDR(sel_addr), .WSEL_READY(wsel_ready), .RSEL_REQ(rsel_req), .RSEL_ADDR(sel_addr),
    .OUT_ENABLE_N(oe_n), .FLAG_DATA(f_dat), .FLAG_VALID(f_val), .FLAG_GROUP(f_grp));
  afb_flag_dev afb_flag_dev_inst (.SYS_CLK(sys_clk), .NRST(nrst), .LNK(lnk.dev),
    .QUEUE_ALMOST_FULL(qaf), .PROG_DONE_N(prog_n), .WRITE_HIT(w_hit), .WRITE_QUEUE(w_q),
    .READ_HIT(r_hit), .READ_QUEUE(r_q), .DEV_ID(dev_id), .IS_MASTER(is_master),
    .POLL_MODE(poll), .IN_WIDTH(in_w), .OUT_WIDTH(out_w), .WIDTH_BAD(width_bad),
    .IN_RESET(in_reset), .QOUT_OE_N(qout_oe_n));
  afb_link_properties afb_link_properties_inst (.SYS_CLK(sys_clk), .NRST(nrst),
    .master_reset_n(lnk.master_reset_n), .master_select(lnk.master_select),
    .id_pins(lnk.id_pins), .serial_program_done(lnk.serial_program_done),
    .full_bus_strobe(lnk.full_bus_strobe), .write_queue_address(lnk.write_queue_address),
    .almost_full_bus_oe_n(lnk.almost_full_bus_oe_n), .full_bus_sync(lnk.full_bus_sync),
    .full_token_in(lnk.full_token_in), .full_token_out(lnk.full_token_out));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  // master reset with new straps; returns once the host is idle again
  task automatic do_reset(input logic [8:0] s);
    int i;
    straps = s;
    reset_req = 1'b1;
    step(1);
    reset_req = 1'b0;
    step(1);
    check(in_reset, 1'b1);
    for (i = 0; i < 8 && reset_busy !== 1'b0; i++) step(1);
    check(reset_busy, 1'b0);
    check(in_reset, 1'b0);
  endtask : do_reset
  // strobe selection; the bus answer is settled two falling edges later
  task automatic fsel(input logic [2:0] d, input logic [1:0] g);
    fsel_dev = d;
    fsel_grp = g;
    fsel_req = 1'b1;
    #1 check(wsel_ready, 1'b0);
    step(1);
    fsel_req = 1'b0;
    step(1);
  endtask : fsel
  task automatic sel(input logic wr, input logic [7:0] a);
    sel_addr = a;
    wsel_req = wr;
    rsel_req = !wr;
    step(1);
    wsel_req = 1'b0;
    rsel_req = 1'b0;
    step(1);
  endtask : sel
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_direct();
    int g;
    do_reset(9'h008); // single device: id 000, master
    check({dev_id, is_master, poll}, 5'h02);
    check(lnk.almost_full_bus_oe_n, 1'b0);
    oe_n = 1'b0;
    #1 check(qout_oe_n, 1'b0);
    oe_n = 1'b1;
    #1 check(qout_oe_n, 1'b1);
    prog_n = 1'b1;
    #1 check(fsel_ready, 1'b0);
    prog_n = 1'b0;
    step(1);
    for (g = 3; g >= 0; g--) begin
      fsel(3'h0, 2'(g));
      check(lnk.almost_full_bus, qaf[8*g +: 8]);
    end
    fsel(3'h6, 2'h1);
    check(lnk.almost_full_bus_oe_n, 1'b1);
    sel(1'b1, 8'h1f);
    check({w_hit, w_q}, 6'h3f);
    sel(1'b1, 8'h3f);
    check(w_hit, 1'b0);
    $display("direct test done");
  endtask : t_direct
  task automatic t_poll();
    int k;
    do_reset(9'h018);
    check(fsel_ready, 1'b0);
    for (k = 0; k < 8; k++) begin
      check(lnk.almost_full_bus, qaf[8*(k%4) +: 8]);
      if (k > 0) begin
        check({f_val, f_grp, f_dat}, {1'b1, 2'(k - 1), qaf[8*((k-1)%4) +: 8]});
      end
      check({lnk.full_bus_sync, lnk.full_token_out}, {k%4 == 0, k%4 == 3});
      step(1);
    end
    $display("polled test done");
  endtask : t_poll
  task automatic t_slave();
    oe_n = 1'b0;
    do_reset(9'h0c5);
    check({in_w, out_w}, {afb_pkg::WID_9, afb_pkg::WID_36});
    check(width_bad, 1'b0);
    check({qout_oe_n, lnk.almost_full_bus_oe_n}, 2'b11);
    sel(1'b0, 8'h03);
    check(qout_oe_n, 1'b1);
    sel(1'b0, 8'ha3);
    check({r_hit, qout_oe_n}, 2'b10);
    check(r_q, 5'h03);
    sel(1'b1, 8'ha7);
    check({w_hit, w_q}, 6'h27);
    fsel(3'h5, 2'h2);
    check({lnk.almost_full_bus_oe_n, lnk.almost_full_bus}, {1'b0, qaf[23:16]});
    $display("slave test done");
  endtask : t_slave
  // hang guard: the scenarios need about fifty cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    step(5);
    nrst = 1'b1;
    step(1);
    t_direct();
    t_poll();
    t_slave();
    finish_test();
  end
endmodule : tb_top
